// [design/pwf_pkg.sv]
/*
  constants for the pseudowire control word and delimiter framer.
  assumes a single 125 mhz core packet clock; no bus, all settings are ports.
*/
// How it works
// - ipv4 protocol code is 0x73
// - ipv6 next header code is 0x73
// - session id carries nonzero bundle id
// - optional 32 or 64 bit cookie follows
// - reserved control word bits sent zero
// - local failure bit follows port setting
// - remote failure bit follows bundle setting
// - defect modifier copied from port setting
// - fragment code 00 01 10 11 meanings
// - length only when below 64 bytes
// - per bundle sequence increments and wraps
// - sequence starts from random value
// - hdlc modes zero, wrap, wrap skipping zero
// - oam sequence separate, copied in reply
// - receiver detects loss and flags late packets
// - rtp sequence equals control word sequence
package pwf_pkg;
  // ---------------------------------------------------------------
  // delimiter codes
  // ---------------------------------------------------------------
  localparam logic [7:0] L2TP_PROTO = 8'h73;
  localparam logic [1:0] COOKIE_NONE = 2'h0;
  localparam logic [1:0] COOKIE_32   = 2'h1;
  localparam logic [1:0] COOKIE_64   = 2'h2;
  // ---------------------------------------------------------------
  // control word layout
  // ---------------------------------------------------------------
  localparam int CW_RES_MSB = 31;
  localparam int CW_L_BIT   = 27;
  localparam int CW_R_BIT   = 26;
  localparam int CW_M_LSB   = 24;
  localparam int CW_FRAG_LSB = 22;
  localparam int CW_LEN_LSB = 16;
  localparam logic [6:0] LEN_LIMIT = 7'h40;
  localparam logic [3:0] CW_RES_VAL = 4'h0;
  localparam logic [1:0] FRAG_WHOLE = 2'h0;
  localparam logic [1:0] FRAG_FIRST = 2'h1;
  localparam logic [1:0] FRAG_LAST  = 2'h2;
  localparam logic [1:0] FRAG_MID   = 2'h3;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  // ---------------------------------------------------------------
  // sequence modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_WRAP     = 2'b00,
    SEQ_ZERO     = 2'b01,
    SEQ_SKIPZERO = 2'b10
  } pwf_seq_mode_t;
endpackage : pwf_pkg

// [design/pwf_seq_table.sv]
/*
  per-bundle sequence memory with random start values.
  assumes one lookup/update per cycle; seeds drawn from a free running lfsr.
*/
`timescale 1ns/1ns
`default_nettype none
module pwf_seq_table #(
  parameter int NB = 64,
  parameter int BW = 6
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // access
  input  wire logic          upd,
  input  wire logic [BW-1:0] idx,
  input  wire logic [1:0]    mode,
  output logic      [15:0]   seq_now
);
  logic [15:0] mem [NB];
  logic [NB-1:0] seeded, next_seeded;
  logic [15:0] lfsr, next_lfsr, cur, nxt;
  always_comb begin
    next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    // unseeded bundle takes whatever the lfsr holds now, so start is unpredictable
    cur = seeded[idx] ? mem[idx] : lfsr;
    seq_now = (mode == 2'(pwf_pkg::SEQ_ZERO)) ? 16'h0000 : cur;
    nxt = cur + 16'h0001;
    if (mode == 2'(pwf_pkg::SEQ_SKIPZERO) && nxt == 16'h0000) begin
      nxt = 16'h0001;
    end
    if (mode == 2'(pwf_pkg::SEQ_SKIPZERO) && seq_now == 16'h0000) begin
      seq_now = 16'h0001;
      nxt = 16'h0002;
    end
    next_seeded = seeded;
    if (upd) begin
      next_seeded[idx] = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lfsr   <= pwf_pkg::LFSR_SEED;
      seeded <= '0;
    end else begin
      lfsr   <= next_lfsr;
      seeded <= next_seeded;
    end
  end
  // memory has no reset; seeded flags guard it
  always_ff @(posedge clk) begin
    if (upd) begin
      mem[idx] <= nxt;
    end
  end
endmodule : pwf_seq_table
`default_nettype wire

// [design/pwf_framer.sv]
/*
  builds l2tpv3 delimiter and pseudowire control word per transmitted packet,
  and checks received control word sequence numbers per bundle.
  assumes one request pulse per packet from the payload engines; host holds settings.
*/
`timescale 1ns/1ns
`default_nettype none
module pwf_framer #(
  parameter int NB = 64,
  parameter int BW = 6
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // transmit request
  input  wire logic          tx_req,
  input  wire logic [BW-1:0] tx_bundle,
  input  wire logic [31:0]   tx_bundle_id,
  input  wire logic          tx_ipv6,
  input  wire logic [1:0]    tx_cookie_size,
  input  wire logic [63:0]   tx_cookie,
  input  wire logic          tx_oam,
  input  wire logic [15:0]   tx_oam_seq,
  input  wire logic [1:0]    tx_seq_mode,
  input  wire logic [1:0]    fragment_position_code,
  input  wire logic [7:0]    tx_len_bytes,
  input  wire logic          tx_udp,
  // host settings
  input  wire logic          port_local_fail,
  input  wire logic [1:0]    port_defect_mod,
  input  wire logic          bundle_remote_fail,
  // transmit result
  output logic               hdr_valid,
  output logic [7:0]         hdr_proto,
  output logic               hdr_is_v6,
  output logic [31:0]        hdr_session,
  output logic [63:0]        hdr_cookie,
  output logic [1:0]         hdr_cookie_size,
  output logic [31:0]        hdr_cw,
  output logic [15:0]        hdr_rtp_seq,
  output logic               hdr_id_err,
  // receive check
  input  wire logic          rx_valid,
  input  wire logic [BW-1:0] rx_bundle,
  input  wire logic [15:0]   rx_seq,
  output logic               rx_loss,
  output logic               rx_late,
  output logic [15:0]        rx_gap
);
  // ---------------------------------------------------------------
  // transmit path
  // ---------------------------------------------------------------
  logic [15:0] seq_now, seq_use;
  logic [5:0]  len6;
  logic [31:0] next_cw;
  logic        data_upd;
  // zero is reserved and must never reach the session field
  function automatic logic id_ok(input logic [31:0] id);
    return id != 32'h0;
  endfunction : id_ok
  assign data_upd = tx_req && !tx_oam && id_ok(tx_bundle_id);
  pwf_seq_table #(.NB(NB), .BW(BW)) i_pwf_seq_table (
    .clk     (clk),
    .rstn    (rstn),
    .upd     (data_upd),
    .idx     (tx_bundle),
    .mode    (tx_seq_mode),
    .seq_now (seq_now)
  );
  logic        next_hdr_valid, next_is_v6, next_id_err;
  logic [31:0] next_session;
  logic [63:0] next_cookie;
  logic [1:0]  next_csize;
  always_comb begin
    // oam messages carry their own query/reply number
    seq_use = tx_oam ? tx_oam_seq : seq_now;
    len6 = ({1'b0, tx_len_bytes} < {1'b0, pwf_pkg::LEN_LIMIT} && !tx_udp) ? tx_len_bytes[5:0] : 6'h00;
    next_cw = {pwf_pkg::CW_RES_VAL, port_local_fail, bundle_remote_fail,
               port_defect_mod, fragment_position_code, len6, seq_use};
    next_hdr_valid = tx_req && id_ok(tx_bundle_id);
    next_id_err = tx_req && !id_ok(tx_bundle_id);
    next_is_v6 = tx_ipv6;
    next_session = tx_bundle_id;
    next_csize = tx_cookie_size;
    case (tx_cookie_size)
      pwf_pkg::COOKIE_32: next_cookie = {32'h0, tx_cookie[31:0]};
      pwf_pkg::COOKIE_64: next_cookie = tx_cookie;
      default: begin
        next_cookie = 64'h0;
        next_csize = pwf_pkg::COOKIE_NONE;
      end
    endcase
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hdr_valid <= 1'b0;
      hdr_proto <= 8'h00;
      hdr_is_v6 <= 1'b0;
      hdr_session <= 32'h0;
      hdr_cookie <= 64'h0;
      hdr_cookie_size <= 2'h0;
      hdr_cw <= 32'h0;
      hdr_rtp_seq <= 16'h0;
      hdr_id_err <= 1'b0;
    end else begin
      hdr_valid <= next_hdr_valid;
      hdr_id_err <= next_id_err;
      if (next_hdr_valid) begin
        hdr_proto <= pwf_pkg::L2TP_PROTO;
        hdr_is_v6 <= next_is_v6;
        hdr_session <= next_session;
        hdr_cookie <= next_cookie;
        hdr_cookie_size <= next_csize;
        hdr_cw <= next_cw;
        hdr_rtp_seq <= seq_use;
      end
    end
  end
  // ---------------------------------------------------------------
  // receive sequence check
  // ---------------------------------------------------------------
  logic [15:0]   exp_mem [NB];
  logic [NB-1:0] rx_seen, next_rx_seen;
  logic [15:0]   diff;
  logic          next_loss, next_late;
  logic [15:0]   next_gap;
  logic          exp_we;
  logic [15:0]   next_exp;
  always_comb begin
    diff = rx_seq - exp_mem[rx_bundle];
    next_rx_seen = rx_seen;
    next_loss = 1'b0;
    next_late = 1'b0;
    next_gap = 16'h0;
    exp_we = rx_valid && (!rx_seen[rx_bundle] || !diff[15]);
    next_exp = rx_seq + 16'h0001;
    if (rx_valid) begin
      next_rx_seen[rx_bundle] = 1'b1;
      if (rx_seen[rx_bundle]) begin
        // half range ahead counts as loss, behind as late for reorder
        if (diff != 16'h0 && !diff[15]) begin
          next_loss = 1'b1;
          next_gap = diff;
        end else if (diff[15]) begin
          next_late = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_seen <= '0;
      rx_loss <= 1'b0;
      rx_late <= 1'b0;
      rx_gap <= 16'h0;
    end else begin
      rx_seen <= next_rx_seen;
      rx_loss <= next_loss;
      rx_late <= next_late;
      rx_gap <= next_gap;
    end
  end
  // late packets do not move the expected number back
  always_ff @(posedge clk) begin
    if (exp_we) begin
      exp_mem[rx_bundle] <= next_exp;
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_proto;
    @(posedge clk) disable iff (!rstn) hdr_valid |-> hdr_proto == 8'h73;
  endproperty
  a_proto: assert property (p_proto) else $error("protocol code wrong");
  property p_res;
    @(posedge clk) disable iff (!rstn) hdr_valid |-> hdr_cw[31:28] == 4'h0;
  endproperty
  a_res: assert property (p_res) else $error("reserved bits set");
  property p_zero_id;
    @(posedge clk) disable iff (!rstn) tx_req && tx_bundle_id == 32'h0 |=> !hdr_valid && hdr_id_err;
  endproperty
  a_zero_id: assert property (p_zero_id) else $error("zero bundle id sent");
  property p_flags;
    @(posedge clk) disable iff (!rstn) next_hdr_valid |=>
      hdr_cw[27] == $past(port_local_fail) && hdr_cw[26] == $past(bundle_remote_fail)
      && hdr_cw[25:24] == $past(port_defect_mod) && hdr_cw[23:22] == $past(fragment_position_code);
  endproperty
  a_flags: assert property (p_flags) else $error("flag bits mismatch");
  property p_len;
    @(posedge clk) disable iff (!rstn) next_hdr_valid && (tx_len_bytes >= 8'h40 || tx_udp) |=> hdr_cw[21:16] == 6'h0;
  endproperty
  a_len: assert property (p_len) else $error("length not zero");
  property p_rtp;
    @(posedge clk) disable iff (!rstn) hdr_valid |-> hdr_rtp_seq == hdr_cw[15:0];
  endproperty
  a_rtp: assert property (p_rtp) else $error("rtp sequence mismatch");
  property p_oam;
    @(posedge clk) disable iff (!rstn) next_hdr_valid && tx_oam |=> hdr_cw[15:0] == $past(tx_oam_seq);
  endproperty
  a_oam: assert property (p_oam) else $error("oam sequence altered");
  property p_skip;
    @(posedge clk) disable iff (!rstn) next_hdr_valid && !tx_oam && tx_seq_mode == 2'b10 |=> hdr_cw[15:0] != 16'h0;
  endproperty
  a_skip: assert property (p_skip) else $error("zero in skip mode");
  property p_incr;
    @(posedge clk) disable iff (!rstn) data_upd && tx_seq_mode == 2'b00 ##1 data_upd && tx_seq_mode == 2'b00
      && tx_bundle == $past(tx_bundle) |=> hdr_cw[15:0] == $past(hdr_cw[15:0]) + 16'h0001;
  endproperty
  a_incr: assert property (p_incr) else $error("sequence not incremented");
  property p_loss_gap;
    @(posedge clk) disable iff (!rstn) rx_loss |-> rx_gap != 16'h0 && !rx_late;
  endproperty
  a_loss_gap: assert property (p_loss_gap) else $error("loss without gap");
  property p_rx_flag;
    @(posedge clk) disable iff (!rstn) rx_valid && rx_seen[rx_bundle] && rx_seq != exp_mem[rx_bundle]
      |=> rx_loss || rx_late;
  endproperty
  a_rx_flag: assert property (p_rx_flag) else $error("sequence jump not flagged");
  // ---------------------------------------------------------------
  // scenarios worth seeing
  // ---------------------------------------------------------------
  c_frag: cover property (@(posedge clk) hdr_valid && hdr_cw[23:22] == 2'b11);
  c_v6: cover property (@(posedge clk) hdr_valid && hdr_is_v6 && hdr_cookie_size == 2'h2);
  c_loss: cover property (@(posedge clk) rx_loss);
  c_late: cover property (@(posedge clk) rx_late);
endmodule : pwf_framer
`default_nettype wire

// [bench/pwf_peer.sv]
/*
  peer endpoint model: hands each transmitted control word back as a received packet.
  assumes the framer's header outputs and a drop request from the bench.
*/
`timescale 1ns/1ns
`default_nettype none
module pwf_peer (
  // header side
  input  wire logic        hdr_valid,
  input  wire logic [31:0] hdr_cw,
  input  wire logic [31:0] hdr_session,
  input  wire logic        drop,
  // receive side
  output logic             rx_valid,
  output logic [5:0]       rx_bundle,
  output logic [15:0]      rx_seq
);
  // a lost packet never shows; idle lines carry garbage, not the last value
  assign rx_valid  = hdr_valid & ~drop;
  // the far end knows the bundle only from the session id it receives
  assign rx_bundle = hdr_session[5:0];
  assign rx_seq    = rx_valid ? hdr_cw[15:0] : ~hdr_cw[15:0];
endmodule : pwf_peer
`default_nettype wire

// [bench/tb.sv]
/*
  self-checking bench for the framer: header codes, control word fields, sequences, loss.
  assumes pwf_peer loops headers back; inputs change at the falling edge.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rstn, tx_req, tx_ipv6, tx_oam, tx_udp, plf, brf, drop;
  logic [5:0]  tx_bundle, rx_bundle;
  logic [31:0] tx_bundle_id, hdr_session, hdr_cw;
  logic [1:0]  tx_cookie_size, tx_seq_mode, frag, pdm, hdr_cookie_size;
  logic [63:0] tx_cookie, hdr_cookie;
  logic [15:0] tx_oam_seq, rx_seq, hdr_rtp_seq, rx_gap, s0, s1;
  logic [7:0]  tx_len_bytes, hdr_proto;
  logic        hdr_valid, hdr_is_v6, hdr_id_err, rx_valid, rx_loss, rx_late;
  int          bad_count, samples_checked;

  always #4 clk = ~clk;

  pwf_framer i_pwf_framer (.clk(clk), .rstn(rstn), .tx_req(tx_req), .tx_bundle(tx_bundle),
    .tx_bundle_id(tx_bundle_id), .tx_ipv6(tx_ipv6), .tx_cookie_size(tx_cookie_size),
    .tx_cookie(tx_cookie), .tx_oam(tx_oam), .tx_oam_seq(tx_oam_seq), .tx_seq_mode(tx_seq_mode),
    .fragment_position_code(frag), .tx_len_bytes(tx_len_bytes), .tx_udp(tx_udp),
    .port_local_fail(plf), .port_defect_mod(pdm), .bundle_remote_fail(brf),
    .hdr_valid(hdr_valid), .hdr_proto(hdr_proto), .hdr_is_v6(hdr_is_v6), .hdr_session(hdr_session),
    .hdr_cookie(hdr_cookie), .hdr_cookie_size(hdr_cookie_size), .hdr_cw(hdr_cw),
    .hdr_rtp_seq(hdr_rtp_seq), .hdr_id_err(hdr_id_err), .rx_valid(rx_valid), .rx_bundle(rx_bundle),
    .rx_seq(rx_seq), .rx_loss(rx_loss), .rx_late(rx_late), .rx_gap(rx_gap));
  pwf_peer i_pwf_peer (.hdr_valid(hdr_valid), .hdr_cw(hdr_cw), .hdr_session(hdr_session), .drop(drop),
    .rx_valid(rx_valid), .rx_bundle(rx_bundle), .rx_seq(rx_seq));

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // caller stands at a falling edge; returns one cycle later with the answer settled
  task automatic pkt(input logic [5:0] b, input logic [31:0] id);
    tx_req = 1'b1;
    tx_bundle = b;
    tx_bundle_id = id;
    @(negedge clk);
  endtask : pkt

  task automatic idle;
    tx_req = 1'b0;
    @(negedge clk);
  endtask : idle

  task automatic t_hdr;
    tx_cookie = 64'h0123456789abcdef;
    for (int i = 0; i < 3; i++) begin
      tx_ipv6 = (i != 0);
      tx_cookie_size = i[1:0];
      pkt(6'h01, 32'h1000 + i);
      chk("valid", hdr_valid, 64'h1);
      chk("proto", hdr_proto, 64'h73);
      chk("is_v6", hdr_is_v6, {63'h0, i != 0});
      chk("session", hdr_session, 64'h1000 + i);
      chk("cookie size", hdr_cookie_size, {62'h0, i[1:0]});
      if (i > 0) chk("cookie", i == 1 ? hdr_cookie[31:0] : hdr_cookie, i == 1 ? 64'h89abcdef : tx_cookie);
    end
    pkt(6'h01, 32'h0);
    chk("zero id valid", hdr_valid, 64'h0);
    chk("zero id err", hdr_id_err, 64'h1);
    idle();
    $display("t_hdr done");
  endtask : t_hdr

  task automatic t_cw;
    for (int i = 0; i < 4; i++) begin
      frag = i[1:0];
      plf = i[0];
      brf = i[1];
      pdm = ~i[1:0];
      tx_len_bytes = i == 0 ? 8'h3f : (i == 1 ? 8'h40 : 8'h0c);
      tx_udp = (i == 3);
      pkt(6'h02, 32'h5);
      chk("cw upper", hdr_cw[31:16], {4'h0, plf, brf, pdm, frag,
        (i == 0 ? 6'h3f : (i == 2 ? 6'h0c : 6'h00))});
    end
    idle();
    $display("t_cw done");
  endtask : t_cw

  task automatic t_seq;
    tx_seq_mode = pwf_pkg::SEQ_WRAP;
    pkt(6'h04, 32'h7);
    s0 = hdr_cw[15:0];
    chk("rtp seq", hdr_rtp_seq, s0);
    pkt(6'h05, 32'h8);
    s1 = hdr_cw[15:0];
    chk("random start differs", s0 === s1, 64'h0);
    pkt(6'h04, 32'h7);
    chk("seq step", hdr_cw[15:0], 16'(s0 + 16'h1));
    tx_oam = 1'b1;
    tx_oam_seq = 16'h5a5a;
    pkt(6'h04, 32'h7);
    chk("oam seq", hdr_cw[15:0], 64'h5a5a);
    tx_oam = 1'b0;
    pkt(6'h04, 32'h7);
    chk("seq after oam", hdr_cw[15:0], 16'(s0 + 16'h2));
    pkt(6'h05, 32'h8);
    chk("other bundle", hdr_cw[15:0], 16'(s1 + 16'h1));
    tx_seq_mode = pwf_pkg::SEQ_ZERO;
    pkt(6'h06, 32'h9);
    chk("zero mode", hdr_cw[15:0], 64'h0);
    tx_seq_mode = pwf_pkg::SEQ_SKIPZERO;
    pkt(6'h06, 32'h9);
    chk("skip zero", hdr_cw[15:0] === 16'h0, 64'h0);
    tx_seq_mode = pwf_pkg::SEQ_WRAP;
    idle();
    $display("t_seq done");
  endtask : t_seq

  task automatic t_rx;
    brf = 1'b0;
    pkt(6'h09, 32'h3);
    pkt(6'h09, 32'h3);
    chk("no loss on first", rx_loss, 64'h0);
    drop = 1'b1;
    pkt(6'h09, 32'h3);
    drop = 1'b0;
    idle();
    chk("loss seen", rx_loss, 64'h1);
    chk("no late on loss", rx_late, 64'h0);
    chk("gap", rx_gap, 64'h1);
    // host answers the loss with remote failure; a stale number then comes back late
    s0 = hdr_cw[15:0];
    brf = 1'b1;
    tx_oam = 1'b1;
    tx_oam_seq = 16'(s0 - 16'h2);
    pkt(6'h09, 32'h3);
    chk("remote fail set", hdr_cw[26], 64'h1);
    tx_oam = 1'b0;
    brf = 1'b0;
    pkt(6'h09, 32'h3);
    chk("late seen", rx_late, 64'h1);
    chk("remote fail cleared", hdr_cw[26], 64'h0);
    idle();
    chk("in order again", {rx_loss, rx_late}, 64'h0);
    idle();
    $display("t_rx done");
  endtask : t_rx

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  initial begin
    {rstn, tx_req, tx_ipv6, tx_oam, tx_udp, plf, brf, drop} = 8'h0;
    {tx_bundle, tx_bundle_id, tx_cookie_size, tx_seq_mode, frag, pdm} = '0;
    {tx_cookie, tx_oam_seq, tx_len_bytes} = '0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    t_hdr();
    t_cw();
    t_seq();
    t_rx();
    test_done();
  end

  // hang guard
  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule : tb
`default_nettype wire
